// file: logic/pdc_pkg.sv
/*
 * pdc_pkg: register map, field positions, reset values and carrier structs
 * for the diagnostic counter and self-test/loopback register block.
 * Assumes a classic Wishbone slave with 32-bit data, registers one word each.
 */
package pdc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] PDC_IDX_FALSE_CARRIER = 8'h14;
    localparam logic [7:0] PDC_IDX_RX_ERROR = 8'h15;
    localparam logic [7:0] PDC_IDX_SELFTEST = 8'h16;
    localparam logic [7:0] PDC_IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] PDC_IDX_IRQ_MASK = 8'h21;
    localparam logic [7:0] PDC_IDX_LINK_CTRL = 8'h22;

    localparam logic [7:0] PDC_FC_MAX = 8'hFF;
    localparam logic [7:0] PDC_FC_HALF = 8'h7F;
    localparam logic [15:0] PDC_RE_MAX = 16'h00FF;
    localparam logic [15:0] PDC_RE_HALF = 16'h007F;
    localparam logic [15:0] PDC_BIST_MAX = 16'hFFFF;

    // self-test register fields
    localparam int PDC_B_CNT_MODE = 14;
    localparam int PDC_B_TEST_HI = 13;
    localparam int PDC_B_TEST_LO = 12;
    localparam int PDC_B_LOCK = 11;
    localparam int PDC_B_SYNC_LOSS = 10;
    localparam int PDC_B_GEN_ACTIVE = 9;
    localparam int PDC_B_POWER = 8;
    localparam int PDC_B_TX_IN_LB = 6;
    localparam int PDC_B_LB_HI = 4;
    localparam logic [15:0] PDC_SELFTEST_RESET = 16'h0100;
    localparam logic [15:0] PDC_SELFTEST_WMASK = 16'h705F;

    // interrupt status/mask bit positions
    localparam int PDC_IRQ_RE_HF = 0;
    localparam int PDC_IRQ_FC_HF = 1;
    localparam int PDC_IRQ_BIST_WRAP = 2;
    localparam int PDC_IRQ_W = 3;

    // link control register: bit 0 mii loopback, bit 1 speed is 100 Mbps
    localparam int PDC_L_MII_LB = 0;
    localparam int PDC_L_SPEED100 = 1;

    typedef enum logic [1:0] {
        PDC_TEST_OFF,
        PDC_TEST_SINGLE,
        PDC_TEST_CHECK,
        PDC_TEST_CONT
    } pdc_test_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } pdc_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pdc_wb_rsp_s;

    // event inputs from the receive path and self-test engine
    typedef struct packed {
        logic false_carrier;
        logic carrier_valid;
        logic receive_data_valid;
        logic invalid_symbol;
        logic bist_error;
        logic checker_locked;
        logic checker_sync_lost;
        logic generator_active;
        logic active_sleep;
    } pdc_evt_s;

    // controls to the datapath
    typedef struct packed {
        logic gen_enable;
        logic gen_continuous;
        logic checker_enable;
        logic tx_in_mii_loopback;
        logic [4:0] loopback_sel;
    } pdc_ctl_s;
endpackage

// file: logic/pdc_bist_counter.sv
/*
 * pdc_bist_counter: self-test error counter, single or continuous mode.
 * Assumes err is a one-cycle pulse per detected checker error.
 */
`timescale 1ns/1ps
module pdc_bist_counter
    import pdc_pkg::*;
#(
    parameter logic [15:0] MAX = pdc_pkg::PDC_BIST_MAX
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic continuous,
    input wire logic err,
    output logic wrap_pulse
);
    typedef struct packed {
        logic [15:0] cnt;
        logic wrap;
    } pdc_bc_s;

    pdc_bc_s st, next_st;

    always_comb begin
        next_st = st;
        next_st.wrap = 1'b0;
        if (!enable) begin
            next_st.cnt = 16'h0000;
        end else if (err) begin
            if (st.cnt != MAX) begin
                next_st.cnt = st.cnt + 16'h0001;
            end else if (continuous) begin
                // continuous: pulse and restart from zero
                next_st.cnt = 16'h0000;
                next_st.wrap = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wrap_pulse = st.wrap;

    a_single_stops: assert property (@(posedge mclk) disable iff (!reset_n)
        (enable && !continuous && st.cnt == MAX) |=> st.cnt == MAX && !st.wrap)
        else $error("single mode counter left max");
endmodule

// file: logic/pdc_diag_regs.sv
/*
 * pdc_diag_regs: false carrier and receive error counters, self-test and
 * loopback control/status register, interrupt status and mask.
 * Assumes event inputs are synchronous to mclk, one-cycle pulses for events.
 */
// How it works
// - eight-bit false carrier counter counts each false carrier event.
// - false carrier counter sticks at FFh until cleared.
// - false carrier count passing 7Fh raises an interrupt event.
// - reading either counter clears it.
// - sixteen-bit receive error counter counts invalid symbols during valid carrier and data.
// - receive error counter holds while MII loopback is on.
// - receive error counter sticks at FFh, raises event above 7Fh.
// - counter mode bit 14 selects stop at max or pulse and restart.
// - bits 13:12 pick off, single packet, checker only, checker plus continuous.
// - bit 11 shows checker locked.
// - bit 10 shows checker sync lost.
// - bit 9 shows packet generator active.
// - bit 8 resets to 1, reads 0 in active sleep.
// - bit 6 forwards transmit data in MII loopback at 100 Mbps only.
// - bits 4:0 select PCS input, PCS output, digital, analog, reverse loopback.
// - false carrier event reaches interrupt only when its mask bit set.
// - receive error event reaches interrupt only when its mask bit set.
`timescale 1ns/1ps
module pdc_diag_regs
    import pdc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input pdc_pkg::pdc_wb_req_s wb_req,
    output pdc_pkg::pdc_wb_rsp_s wb_rsp,
    input pdc_pkg::pdc_evt_s evt,
    output pdc_pkg::pdc_ctl_s ctl,
    output logic irq
);
    import pdc_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] fc;
        logic [15:0] re;
        logic cnt_mode;
        logic [1:0] test_mode;
        logic tx_in_lb;
        logic [4:0] lb_sel;
        logic [PDC_IRQ_W-1:0] status;
        logic [PDC_IRQ_W-1:0] mask;
        logic [1:0] link;
    } pdc_st_s;

    pdc_st_s st, next_st;
    logic bist_wrap;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] word_index(input logic [9:0] adr);
        word_index = adr[9:2];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) merge16[7:0] = d[7:0];
        if (sel[1]) merge16[15:8] = d[15:8];
    endfunction

    function automatic logic legal_loopback(input logic [4:0] v);
        legal_loopback = (v == 5'h00) || (v == 5'h01) || (v == 5'h02) ||
                         (v == 5'h04) || (v == 5'h08) || (v == 5'h10);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // self-test error counter

    pdc_bist_counter #(
        .MAX(PDC_BIST_MAX)
    ) u_bist (
        .mclk(mclk),
        .reset_n(reset_n),
        .enable(st.test_mode[1]),
        .continuous(st.cnt_mode),
        .err(evt.bist_error),
        .wrap_pulse(bist_wrap)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic req;
    logic rd_fc;
    logic rd_re;
    logic [7:0] idx;
    logic [15:0] selftest_rd;
    logic [15:0] wv;
    logic fc_inc;
    logic re_inc;
    logic [PDC_IRQ_W-1:0] evt_set;

    always_comb begin
        req = wb_req.cyc && wb_req.stb && !st.ack;
        idx = word_index(wb_req.adr);
        rd_fc = req && !wb_req.we && idx == PDC_IDX_FALSE_CARRIER;
        rd_re = req && !wb_req.we && idx == PDC_IDX_RX_ERROR;
        fc_inc = evt.false_carrier && st.fc != PDC_FC_MAX;
        re_inc = evt.carrier_valid && evt.receive_data_valid && evt.invalid_symbol
                 && !st.link[PDC_L_MII_LB]
                 && st.re != PDC_RE_MAX;
        evt_set = '0;
        evt_set[PDC_IRQ_FC_HF] = fc_inc && st.fc == PDC_FC_HALF;
        evt_set[PDC_IRQ_RE_HF] = re_inc && st.re == PDC_RE_HALF;
        evt_set[PDC_IRQ_BIST_WRAP] = bist_wrap;

        selftest_rd = '0;
        selftest_rd[PDC_B_CNT_MODE] = st.cnt_mode;
        selftest_rd[PDC_B_TEST_HI:PDC_B_TEST_LO] = st.test_mode;
        selftest_rd[PDC_B_LOCK] = evt.checker_locked;
        selftest_rd[PDC_B_SYNC_LOSS] = evt.checker_sync_lost;
        selftest_rd[PDC_B_GEN_ACTIVE] = evt.generator_active;
        selftest_rd[PDC_B_POWER] = !evt.active_sleep;
        selftest_rd[PDC_B_TX_IN_LB] = st.tx_in_lb;
        selftest_rd[PDC_B_LB_HI:0] = st.lb_sel;

        next_st = st;
        next_st.ack = req;
        // read clears, but an event in the same cycle still counts from zero unless the counter sat at its max
        if (rd_fc) begin
            next_st.fc = {7'h00, fc_inc};
        end else if (fc_inc) begin
            next_st.fc = st.fc + 8'h01;
        end
        if (rd_re) begin
            next_st.re = {15'h0000, re_inc};
        end else if (re_inc) begin
            next_st.re = st.re + 16'h0001;
        end

        next_st.rdat = 32'h0000_0000;
        wv = 16'h0000;
        if (req && !wb_req.we) begin
            case (idx)
                PDC_IDX_FALSE_CARRIER: next_st.rdat = {24'h000000, st.fc};
                PDC_IDX_RX_ERROR: next_st.rdat = {16'h0000, st.re};
                PDC_IDX_SELFTEST: next_st.rdat = {16'h0000, selftest_rd};
                PDC_IDX_IRQ_STATUS: next_st.rdat = {29'h0, st.status};
                PDC_IDX_IRQ_MASK: next_st.rdat = {29'h0, st.mask};
                PDC_IDX_LINK_CTRL: next_st.rdat = {30'h0, st.link};
                default: next_st.rdat = 32'h0000_0000;
            endcase
        end

        next_st.status = st.status;
        if (req && wb_req.we) begin
            case (idx)
                PDC_IDX_SELFTEST: begin
                    wv = merge16(selftest_rd, wb_req.dat, wb_req.sel) & PDC_SELFTEST_WMASK;
                    next_st.cnt_mode = wv[PDC_B_CNT_MODE];
                    next_st.test_mode = wv[PDC_B_TEST_HI:PDC_B_TEST_LO];
                    // only accepted while mii loopback is on at 100 Mbps
                    next_st.tx_in_lb = wv[PDC_B_TX_IN_LB] && st.link[PDC_L_MII_LB]
                                       && st.link[PDC_L_SPEED100];
                    // unsupported codes are ignored; speed suitability is software's
                    if (legal_loopback(wv[PDC_B_LB_HI:0])) begin
                        next_st.lb_sel = wv[PDC_B_LB_HI:0];
                    end
                end
                PDC_IDX_IRQ_STATUS: begin
                    if (wb_req.sel[0]) begin
                        next_st.status = st.status & ~wb_req.dat[PDC_IRQ_W-1:0];
                    end
                end
                PDC_IDX_IRQ_MASK: begin
                    if (wb_req.sel[0]) begin
                        next_st.mask = wb_req.dat[PDC_IRQ_W-1:0];
                    end
                end
                PDC_IDX_LINK_CTRL: begin
                    if (wb_req.sel[0]) begin
                        next_st.link = wb_req.dat[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // set wins over a write-one clear
        next_st.status = next_st.status | evt_set;
        // forwarding falls away when mii loopback or 100 Mbps drops
        if (!next_st.link[PDC_L_MII_LB] || !next_st.link[PDC_L_SPEED100]) begin
            next_st.tx_in_lb = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_rsp.ack = st.ack;
    assign wb_rsp.dat = st.rdat;
    assign irq = |(st.status & st.mask);

    always_comb begin
        ctl.checker_enable = st.test_mode[1];
        ctl.gen_enable = st.test_mode[0];
        ctl.gen_continuous = st.test_mode == PDC_TEST_CONT;
        ctl.tx_in_mii_loopback = st.tx_in_lb;
        ctl.loopback_sel = st.lb_sel;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_fc_saturate: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.fc == PDC_FC_MAX && !rd_fc) |=> st.fc == PDC_FC_MAX)
        else $error("false carrier counter left saturation");

    a_fc_counts: assert property (@(posedge mclk) disable iff (!reset_n)
        (evt.false_carrier && !rd_fc && st.fc != PDC_FC_MAX) |=> st.fc == $past(st.fc) + 8'h01)
        else $error("false carrier counter did not count");

    a_fc_half: assert property (@(posedge mclk) disable iff (!reset_n)
        (evt.false_carrier && st.fc == PDC_FC_HALF) |=> st.status[PDC_IRQ_FC_HF])
        else $error("false carrier half-full not flagged");

    a_read_clears: assert property (@(posedge mclk) disable iff (!reset_n)
        (rd_re && !re_inc) |=> st.re == 16'h0000)
        else $error("receive error counter not cleared on read");

    a_read_old: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_fc |=> wb_rsp.ack && wb_rsp.dat == {24'h000000, $past(st.fc)})
        else $error("read did not return pre-clear count");

    a_re_loop_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.link[PDC_L_MII_LB] && !rd_re) |=> st.re == $past(st.re))
        else $error("receive error counter moved in loopback");

    a_re_saturate: assert property (@(posedge mclk) disable iff (!reset_n)
        st.re <= PDC_RE_MAX)
        else $error("receive error counter beyond max");

    a_irq_masked: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.status[PDC_IRQ_FC_HF] && st.mask[PDC_IRQ_FC_HF]) |-> irq)
        else $error("unmasked false carrier event missing on irq");

    a_irq_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        ((st.status & st.mask) == '0) |-> !irq)
        else $error("irq high with no unmasked status");

    a_tx_lb_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        st.tx_in_lb |-> st.link[PDC_L_MII_LB] && st.link[PDC_L_SPEED100])
        else $error("forwarding set outside mii loopback");

    a_fc_clears: assert property (@(posedge mclk) disable iff (!reset_n)
        (rd_fc && !evt.false_carrier) |=> st.fc == 8'h00)
        else $error("false carrier counter not cleared on read");

    a_fc_idle_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        (!evt.false_carrier && !rd_fc) |=> st.fc == $past(st.fc))
        else $error("false carrier counter moved without an event");

    a_re_read_old: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_re |=> wb_rsp.ack && wb_rsp.dat == {16'h0000, $past(st.re)})
        else $error("receive error read did not return pre-clear count");

    a_re_counts: assert property (@(posedge mclk) disable iff (!reset_n)
        (evt.carrier_valid && evt.receive_data_valid && evt.invalid_symbol
         && !st.link[PDC_L_MII_LB] && !rd_re && st.re != PDC_RE_MAX)
        |=> st.re == $past(st.re) + 16'h0001)
        else $error("receive error counter did not count");

    a_re_idle_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        (!(evt.carrier_valid && evt.receive_data_valid && evt.invalid_symbol) && !rd_re)
        |=> st.re == $past(st.re))
        else $error("receive error counter moved outside valid data");

    a_re_half: assert property (@(posedge mclk) disable iff (!reset_n)
        (evt.carrier_valid && evt.receive_data_valid && evt.invalid_symbol
         && !st.link[PDC_L_MII_LB] && st.re == PDC_RE_HALF) |=> st.status[PDC_IRQ_RE_HF])
        else $error("receive error half-full not flagged");

    a_re_max_stays: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.re == PDC_RE_MAX && !rd_re) |=> st.re == PDC_RE_MAX)
        else $error("receive error counter left saturation");

    a_status_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.status[PDC_IRQ_FC_HF] && !(req && wb_req.we && idx == PDC_IDX_IRQ_STATUS))
        |=> st.status[PDC_IRQ_FC_HF])
        else $error("false carrier event lost without a clear");

    a_bist_status: assert property (@(posedge mclk) disable iff (!reset_n)
        bist_wrap |=> st.status[PDC_IRQ_BIST_WRAP])
        else $error("self-test wrap pulse not flagged");

    a_test_mode_wr: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && wb_req.we && idx == PDC_IDX_SELFTEST && wb_req.sel[1])
        |=> st.test_mode == $past(wb_req.dat[PDC_B_TEST_HI:PDC_B_TEST_LO]))
        else $error("test mode field not written");

    a_lock_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && !wb_req.we && idx == PDC_IDX_SELFTEST)
        |=> wb_rsp.dat[PDC_B_LOCK] == $past(evt.checker_locked))
        else $error("lock bit does not follow checker");

    a_sync_loss_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && !wb_req.we && idx == PDC_IDX_SELFTEST)
        |=> wb_rsp.dat[PDC_B_SYNC_LOSS] == $past(evt.checker_sync_lost))
        else $error("sync loss bit does not follow checker");

    a_gen_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && !wb_req.we && idx == PDC_IDX_SELFTEST)
        |=> wb_rsp.dat[PDC_B_GEN_ACTIVE] == $past(evt.generator_active))
        else $error("generator bit does not follow generator");

    a_power_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && !wb_req.we && idx == PDC_IDX_SELFTEST)
        |=> wb_rsp.dat[PDC_B_POWER] == !$past(evt.active_sleep))
        else $error("power bit does not follow sleep state");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && !wb_req.we && idx == PDC_IDX_SELFTEST)
        |=> wb_rsp.dat[31:15] == 17'h00000 && !wb_rsp.dat[7] && !wb_rsp.dat[5])
        else $error("reserved self-test bits not zero");

    a_lb_onehot: assert property (@(posedge mclk) disable iff (!reset_n)
        $onehot0(st.lb_sel))
        else $error("loopback select holds an unsupported code");

    a_lb_ignore: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && wb_req.we && idx == PDC_IDX_SELFTEST && wb_req.sel[0]
         && !$onehot0(wb_req.dat[PDC_B_LB_HI:0])) |=> st.lb_sel == $past(st.lb_sel))
        else $error("unsupported loopback code was taken");

    a_tx_lb_write: assert property (@(posedge mclk) disable iff (!reset_n)
        (req && wb_req.we && idx == PDC_IDX_SELFTEST && wb_req.sel[0]
         && wb_req.dat[PDC_B_TX_IN_LB] && st.link[PDC_L_MII_LB] && st.link[PDC_L_SPEED100])
        |=> st.tx_in_lb)
        else $error("forwarding not taken in mii loopback at 100 Mbps");

    a_irq_re: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.status[PDC_IRQ_RE_HF] && st.mask[PDC_IRQ_RE_HF]) |-> irq)
        else $error("unmasked receive error event missing on irq");

    a_ack_single: assert property (@(posedge mclk) disable iff (!reset_n)
        wb_rsp.ack |=> !wb_rsp.ack)
        else $error("acknowledge stood longer than one cycle");
endmodule

// file: dv/pdc_rx_model.sv
/*
 * pdc_rx_model: receive path and self-test engine seen from the register block.
 * Assumes the bench calls its tasks; every change lands just after a clock edge.
 */
`timescale 1ns/1ps
module pdc_rx_model
    import pdc_pkg::*;
(
    input wire logic mclk,
    output pdc_pkg::pdc_evt_s evt
);
    initial evt = '0;
    ////////////////////////////////////////////////////////////////////////////
    // a quiet edge between events so no two merge into one
    task automatic fc_burst(input int n);
        repeat (n) begin
            @(posedge mclk) evt.false_carrier <= 1'b1;
            @(posedge mclk) evt.false_carrier <= 1'b0;
        end
    endtask
    // carrier framing around the bad symbols; dv low shows symbols outside data
    task automatic sym_burst(input int n, input logic dv);
        @(posedge mclk) evt.carrier_valid <= 1'b1;
        evt.receive_data_valid <= dv;
        repeat (n) begin
            @(posedge mclk) evt.invalid_symbol <= 1'b1;
            @(posedge mclk) evt.invalid_symbol <= 1'b0;
        end
        @(posedge mclk) evt.carrier_valid <= 1'b0;
        evt.receive_data_valid <= 1'b0;
    endtask
    // levels: lock, sync loss, generator active, active sleep
    task automatic set_status(input logic [3:0] s);
        @(posedge mclk) evt.checker_locked <= s[3];
        evt.checker_sync_lost <= s[2];
        evt.generator_active <= s[1];
        evt.active_sleep <= s[0];
    endtask
    // checker errors on n edges in a row
    task automatic bist_run(input int n);
        @(posedge mclk) evt.bist_error <= 1'b1;
        repeat (n) @(posedge mclk);
        evt.bist_error <= 1'b0;
    endtask
endmodule

// file: dv/pdc_diag_regs_tb_top.sv
/*
 * pdc_diag_regs_tb_top: self-checking bench for the diagnostic register block.
 * Assumes a one-cycle Wishbone answer and event sources from pdc_rx_model.
 */
`timescale 1ns/1ps
module pdc_diag_regs_tb_top;
    import pdc_pkg::*;
    localparam logic [9:0] A_FC = {PDC_IDX_FALSE_CARRIER, 2'b00};
    localparam logic [9:0] A_RE = {PDC_IDX_RX_ERROR, 2'b00};
    localparam logic [9:0] A_ST = {PDC_IDX_SELFTEST, 2'b00};
    localparam logic [9:0] A_STAT = {PDC_IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] A_MASK = {PDC_IDX_IRQ_MASK, 2'b00};
    localparam logic [9:0] A_LINK = {PDC_IDX_LINK_CTRL, 2'b00};
    logic mclk;
    logic reset_n;
    pdc_wb_req_s req;
    pdc_wb_rsp_s rsp;
    pdc_evt_s evt;
    pdc_ctl_s ctl;
    logic irq;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [4:0] codes [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};

    pdc_diag_regs i_dut (.mclk(mclk), .reset_n(reset_n), .wb_req(req), .wb_rsp(rsp),
        .evt(evt), .ctl(ctl), .irq(irq));
    pdc_rx_model i_rx (.mclk(mclk), .evt(evt));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // the self-test wrap run alone takes some 65600 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // classic cycle: hold everything until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge mclk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
        do @(posedge mclk); while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(A_FC, 32'h0);
        rd(A_RE, 32'h0);
        rd(A_ST, 32'h100);
        rd(A_MASK, 32'h0);
        rd(10'h3FC, 32'h0);
    endtask
    task automatic t_false_carrier;
        i_rx.fc_burst(128);
        rd(A_STAT, 32'h2);
        chk_bit(irq, 1'b0);
        rd(A_FC, 32'h80);
        rd(A_FC, 32'h0);
        wr(A_MASK, 32'h2);
        repeat (2) @(posedge mclk);
        chk_bit(irq, 1'b1);
        wr(A_STAT, 32'h2);
        repeat (2) @(posedge mclk);
        chk_bit(irq, 1'b0);
        i_rx.fc_burst(127);
        rd(A_STAT, 32'h0);
        i_rx.fc_burst(173);
        rd(A_FC, 32'hFF);
        wr(A_STAT, 32'h7);
        wr(A_MASK, 32'h0);
    endtask
    task automatic t_rx_error;
        wr(A_LINK, 32'h1);
        i_rx.sym_burst(5, 1'b1);
        rd(A_RE, 32'h0);
        wr(A_LINK, 32'h0);
        i_rx.sym_burst(5, 1'b0);
        rd(A_RE, 32'h0);
        i_rx.sym_burst(128, 1'b1);
        rd(A_STAT, 32'h1);
        wr(A_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk_bit(irq, 1'b1);
        rd(A_RE, 32'h80);
        i_rx.sym_burst(300, 1'b1);
        rd(A_RE, 32'hFF);
        wr(A_STAT, 32'h7);
        wr(A_MASK, 32'h0);
    endtask
    task automatic t_selftest;
        for (int m = 0; m < 4; m++) begin
            wr(A_ST, (32'(m) << 12) | 32'h4000);
            rd(A_ST, (32'(m) << 12) | 32'h4100);
            chk_bit(ctl.gen_enable, m[0]);
            chk_bit(ctl.checker_enable, m[1]);
            chk_bit(ctl.gen_continuous, m == 3);
        end
        wr(A_ST, 32'h0);
        i_rx.set_status(4'hF);
        rd(A_ST, 32'hE00);
        i_rx.set_status(4'h0);
        for (int i = 0; i < 5; i++) begin
            wr(A_LINK, (codes[i] == 5'h04) ? 32'h2 : 32'h0);
            wr(A_ST, {27'h0, codes[i]});
            rd(A_ST, 32'h100 | {27'h0, codes[i]});
            chk({27'h0, ctl.loopback_sel}, {27'h0, codes[i]});
        end
        wr(A_ST, 32'h3);
        rd(A_ST, 32'h110);
        wr(A_LINK, 32'h0);
        wr(A_ST, 32'h40);
        rd(A_ST, 32'h100);
        wr(A_LINK, 32'h3);
        wr(A_ST, 32'h40);
        rd(A_ST, 32'h140);
        chk_bit(ctl.tx_in_mii_loopback, 1'b1);
        wr(A_LINK, 32'h2);
        rd(A_ST, 32'h100);
    endtask
    // counter fills to its max in continuous mode, then one error each in single and continuous
    task automatic t_bist;
        wr(A_ST, 32'h6000);
        i_rx.bist_run(65535);
        rd(A_STAT, 32'h0);
        wr(A_ST, 32'h2000);
        i_rx.bist_run(1);
        rd(A_STAT, 32'h0);
        wr(A_ST, 32'h6000);
        i_rx.bist_run(1);
        rd(A_STAT, 32'h4);
        wr(A_MASK, 32'h4);
        chk_bit(irq, 1'b1);
        wr(A_STAT, 32'h7);
        wr(A_MASK, 32'h0);
        wr(A_ST, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        req = '0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_false_carrier();
        t_rx_error();
        t_selftest();
        t_bist();
        report_and_stop();
    end
endmodule
